// File: dv/host_model.sv
// host controller model: one enable-low cycle per go request
// assumes device outputs change on the same clock edge as this model
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// request from bench
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic       rd_i,
	input  wire logic       bad_i,
	input  wire logic [5:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [2:0] hold_i,
	// device side
	input  wire logic       ack_i,
	input  wire logic [7:0] dev_d_i,
	input  wire logic       dev_oe_i,
	input  wire logic       dev_p_i,
	output logic            en_b_o,
	output logic            rw_o,
	output logic [5:0]      addr_o,
	output logic [7:0]      d_o,
	output logic            p_o,
	output logic            done_o,
	output logic [8:0]      rd_o
);
	logic [8:0] lastb;
	logic [2:0] cnt;
	wire logic  drv = ~en_b_o & ~rd_i;
	assign rw_o = rd_i;
	assign addr_o = addr_i;
	// undriven bus flips each cycle so stale data never looks valid
	assign d_o = dev_oe_i ? dev_d_i : drv ? wdata_i : ~lastb[7:0];
	assign p_o = dev_oe_i ? dev_p_i : drv ? (~^wdata_i ^ bad_i) : ~lastb[8];
	initial begin
		en_b_o = 1'b1;
		done_o = 1'b0;
		cnt = '0;
		lastb = '0;
		rd_o = '0;
	end
	always @(posedge clk_i) begin
		lastb <= {p_o, d_o};
		done_o <= 1'b0;
		if (en_b_o && go_i && !done_o) en_b_o <= 1'b0;
		else if (!en_b_o && ack_i) begin
			if (cnt == hold_i) begin
				rd_o <= {p_o, d_o};
				en_b_o <= 1'b1;
				done_o <= 1'b1;
				cnt <= '0;
			end else cnt <= cnt + 3'h1;
		end
	end
endmodule // host_model
`default_nettype wire

// File: dv/tb_async_control_bus_port.sv
// self-checking bench for the async register port
// assumes host_model drives all host pins
`timescale 1ns/10ps
`default_nettype none
`include "cbus_port_regs.svh"
module tb_async_control_bus_port;
	import cbus_port_pkg::*;
	logic mclk_i = 1'b0, rst_b_i = 1'b0, go = 1'b0, rd = 1'b0, bad = 1'b0;
	logic [5:0] addr = '0, a;
	logic [7:0] wd = '0, ev = '0, d;
	logic [2:0] hold = '0;
	logic en_b, rw, hp, done, dp, doe, poe, ackoe, intoe, ackb, intb;
	logic [5:0] ha;
	logic [7:0] hd, dd;
	logic [8:0] rdv;
	logic [`REG_COUNT-1:0][`DATA_W-1:0] img;
	int err_total = 0, n_checks = 0, cyc = 0;
	initial forever #5 mclk_i = ~mclk_i;
	host_model u_host_model (.clk_i(mclk_i), .go_i(go), .rd_i(rd), .bad_i(bad), .addr_i(addr),
		.wdata_i(wd), .hold_i(hold), .ack_i(ackoe), .dev_d_i(dd), .dev_oe_i(doe), .dev_p_i(dp),
		.en_b_o(en_b), .rw_o(rw), .addr_o(ha), .d_o(hd), .p_o(hp), .done_o(done), .rd_o(rdv));
	async_control_bus_port u_async_control_bus_port (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.enable_b_i(en_b), .rd_wr_i(rw), .host_addr_i(ha), .host_data_i(hd), .host_data_o(dd),
		.host_data_oe_o(doe), .host_odd_parity_i(hp), .host_odd_parity_o(dp),
		.host_odd_parity_oe_o(poe), .ack_b_o(ackb), .ack_b_oe_o(ackoe), .int_b_o(intb),
		.int_b_oe_o(intoe), .cond_event_i(ev), .reg_image_o(img));
	task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic odd_par(input logic [7:0] v);
		return ~^v;
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic acc(input logic r, input logic [5:0] ad, input logic [7:0] v, input logic b);
		int k;
		@(posedge mclk_i);
		{rd, addr, wd, bad, go} <= {r, ad, v, b, 1'b1};
		hold <= 3'($urandom_range(7));
		k = 0;
		do begin
			@(posedge mclk_i);
			#1 k++;
		end while (!done && k < 40);
		chk("ack held", {8'h00, ackoe}, 9'h001);
		@(posedge mclk_i);
		go <= 1'b0;
		repeat (4) @(posedge mclk_i);
		#1 chk("release", {4'h0, ackb, intb, ackoe, doe, poe}, 9'h000);
	endtask
	task automatic settle();
		repeat (3) @(posedge mclk_i);
		#1;
	endtask
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(8266));
		repeat (8) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		for (int i = 0; i < 12; i++) begin
			a = (i == 0) ? 6'h3F : (i == 1) ? 6'h02 : 6'($urandom_range(63, 2));
			d = 8'($urandom);
			acc(1'b0, a, d, 1'b0);
			chk("image", {1'b0, img[a]}, {1'b0, d});
			acc(1'b1, a, 8'h00, 1'b0);
			chk("rdata", rdv, {odd_par(d), d});
		end
		$display("test read write done");
		acc(1'b0, a, ~d, 1'b1);
		chk("blocked", {1'b0, img[a]}, {1'b0, d});
		chk("perr flag", {1'b0, img[0]}, 9'h001);
		chk("masked", {8'h00, intoe}, 9'h000);
		$display("test parity done");
		acc(1'b0, 6'h01, 8'hFF, 1'b0);
		settle();
		chk("int on", {8'h00, intoe}, 9'h001);
		acc(1'b1, 6'h00, 8'h00, 1'b0);
		chk("cond read", rdv, 9'h001);
		acc(1'b0, 6'h00, 8'h01, 1'b0);
		settle();
		chk("int off", {8'h00, intoe}, 9'h000);
		d = 8'($urandom) | 8'h02;
		@(posedge mclk_i);
		ev <= d;
		@(posedge mclk_i);
		ev <= 8'h00;
		settle();
		chk("event", {intoe, img[0]}, {1'b1, d});
		acc(1'b0, 6'h01, 8'h00, 1'b0);
		settle();
		chk("mask off", {8'h00, intoe}, 9'h000);
		$display("test interrupt done");
		tally_and_finish();
	end
endmodule // tb_async_control_bus_port
`default_nettype wire

// File: src/async_control_bus_port.sv
// asynchronous host register port with 64 x 8 register file and interrupt pin
// assumes all host pins are asynchronous and core events are on mclk_i
`timescale 1ns/10ps
`default_nettype none
`include "cbus_port_regs.svh"

module async_control_bus_port
	import cbus_port_pkg::*;
(
	// clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 rst_b_i,
	// host control pins
	input  wire logic                 enable_b_i,
	input  wire logic                 rd_wr_i,
	input  wire logic [`ADDR_W-1:0]   host_addr_i,
	// host data and parity, two-way
	input  wire logic [`DATA_W-1:0]   host_data_i,
	output logic      [`DATA_W-1:0]   host_data_o,
	output logic                      host_data_oe_o,
	input  wire logic                 host_odd_parity_i,
	output logic                      host_odd_parity_o,
	output logic                      host_odd_parity_oe_o,
	// open-drain acknowledge and interrupt
	output logic                      ack_b_o,
	output logic                      ack_b_oe_o,
	output logic                      int_b_o,
	output logic                      int_b_oe_o,
	// core side
	input  wire logic [`DATA_W-1:0]   cond_event_i,
	output logic      [`REG_COUNT-1:0][`DATA_W-1:0] reg_image_o
);

	port_state_vec_t s;
	port_state_vec_t next_s;
	logic            par_good;
	logic [`DATA_W-1:0] cond_set;
	logic [`DATA_W-1:0] cond_clr;

	// odd parity: data bits plus parity bit carry an odd count of ones
	assign par_good = ^{s.wdata, s.wpar};

	always_comb begin
		next_s = s;
		cond_set = cond_event_i;
		cond_clr = '0;
		// two-flop synchronisers; only stage two is read by logic
		next_s.ce_s1 = enable_b_i;
		next_s.ce_s2 = s.ce_s1;
		next_s.rw_s1 = rd_wr_i;
		next_s.rw_s2 = s.rw_s1;
		next_s.addr_s1 = host_addr_i;
		next_s.addr_s2 = s.addr_s1;
		next_s.data_s1 = host_data_i;
		next_s.data_s2 = s.data_s1;
		next_s.par_s1 = host_odd_parity_i;
		next_s.par_s2 = s.par_s1;
		next_s.od_low = 1'b0;
		case (s.st)
			ST_IDLE: begin
				if (!s.ce_s2) begin
					next_s.st = ST_SETTLE;
				end
			end
			// one extra cycle lets every synchronised input line up after the enable
			ST_SETTLE: begin
				next_s.rd = s.rw_s2;
				next_s.addr = s.addr_s2;
				next_s.wdata = s.data_s2;
				next_s.wpar = s.par_s2;
				next_s.st = ST_ACCESS;
			end
			ST_ACCESS: begin
				if (s.rd) begin
					next_s.dout = s.regs[s.addr];
					next_s.pout = ~^s.regs[s.addr];
					next_s.data_oe = 1'b1;
					next_s.par_oe = 1'b1;
				// parity refused before decode, so the condition register is shielded too
				end else if (!par_good) begin
					cond_set[`PERR_BIT] = 1'b1;
				end else if (s.addr == `COND_ADDR) begin
					cond_clr = s.wdata;
				end else begin
					next_s.regs[s.addr] = s.wdata;
				end
				next_s.ack_oe = 1'b1;
				next_s.st = ST_HOLD;
			end
			ST_HOLD: begin
				if (s.ce_s2) begin
					next_s.ack_oe = 1'b0;
					next_s.data_oe = 1'b0;
					next_s.par_oe = 1'b0;
					next_s.st = ST_IDLE;
				end
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase
		// write-one-to-clear; a new event in the same cycle wins
		next_s.regs[`COND_ADDR] = (s.regs[`COND_ADDR] & ~cond_clr) | cond_set;
		// level output, one cycle behind the condition and mask registers
		next_s.int_oe = |(s.regs[`COND_ADDR] & s.regs[`MASK_ADDR]);
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.ce_s1 <= 1'b1;
			s.ce_s2 <= 1'b1;
			for (int i = 0; i < `REG_COUNT; i++) begin
				s.regs[i] <= `REG_RESET;
			end
			s.regs[`COND_ADDR] <= `COND_RESET;
			s.regs[`MASK_ADDR] <= `MASK_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign host_data_o = s.dout;
	assign host_data_oe_o = s.data_oe;
	assign host_odd_parity_o = s.pout;
	assign host_odd_parity_oe_o = s.par_oe;
	assign ack_b_o = s.od_low;
	assign ack_b_oe_o = s.ack_oe;
	assign int_b_o = s.od_low;
	assign int_b_oe_o = s.int_oe;
	assign reg_image_o = s.regs;

	// checks
	// every check reads registered state or the cond_event_i input, never a raw host pin

	start_only_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.st == ST_SETTLE) |-> ($past(s.st) == ST_IDLE && !$past(s.ce_s2)))
		else $error("cycle started without synchronised enable");

	rw_capture_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.st == ST_SETTLE) |=> (s.rd == $past(s.rw_s2)))
		else $error("read/write select not captured");

	addr_capture_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.st == ST_SETTLE) |=> (s.addr == $past(s.addr_s2)))
		else $error("address not captured");

	read_load_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.st == ST_ACCESS && s.rd) |=> (s.dout == $past(s.regs[s.addr]) && s.data_oe && s.par_oe))
		else $error("read data not loaded from addressed register");

	write_quiet_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.ack_oe && !s.rd) |-> (!s.data_oe && !s.par_oe))
		else $error("data lines driven during a write");

	idle_quiet_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.st == ST_IDLE) |-> (!s.ack_oe && !s.data_oe && !s.par_oe))
		else $error("drivers active while idle");

	hold_stay_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.st == ST_HOLD && !s.ce_s2) |=> (s.st == ST_HOLD))
		else $error("hold left while enable low");

	perr_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.regs[`COND_ADDR][`PERR_BIT]
		&& !(s.st == ST_ACCESS && !s.rd && par_good && s.addr == `COND_ADDR))
		|=> s.regs[`COND_ADDR][`PERR_BIT])
		else $error("parity error flag lost without clear");

	cond_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.st == ST_ACCESS && !s.rd && par_good && s.addr == `COND_ADDR && cond_event_i == '0)
		|=> (s.regs[`COND_ADDR] == ($past(s.regs[`COND_ADDR]) & ~$past(s.wdata))))
		else $error("condition clear wrong");

	event_set_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(cond_event_i != '0) |=> ((s.regs[`COND_ADDR] & $past(cond_event_i)) == $past(cond_event_i)))
		else $error("condition event not recorded");

	idle_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.st == ST_IDLE && s.ce_s2) |=> (s.st == ST_IDLE && !s.ack_oe))
		else $error("cycle started without enable");

	ack_start_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.st == ST_IDLE && !s.ce_s2) |-> ##3 s.ack_oe)
		else $error("acknowledge not asserted three cycles after enable");

	ack_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.ack_oe && !s.ce_s2) |=> s.ack_oe)
		else $error("acknowledge dropped while enable low");

	ack_release_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.ack_oe && s.ce_s2) |=> (!s.ack_oe && !s.data_oe && !s.par_oe))
		else $error("drivers not released after enable rose");

	read_drive_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.ack_oe && s.rd) |-> (s.data_oe && s.par_oe)
		##1 (!s.ack_oe || $stable(s.dout)))
		else $error("read data not held while acknowledge low");

	read_parity_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		s.par_oe |-> (^{s.dout, s.pout}))
		else $error("read parity not odd");

	bad_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.st == ST_ACCESS && !s.rd && !par_good && s.addr != `COND_ADDR)
		|=> (s.regs[`COND_ADDR][`PERR_BIT] && $stable(s.regs[s.addr])))
		else $error("bad parity write not blocked");

	good_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.st == ST_ACCESS && !s.rd && par_good && s.addr != `COND_ADDR)
		|=> (s.regs[s.addr] == s.wdata))
		else $error("good write not stored");

	int_mask_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.regs[`COND_ADDR] & s.regs[`MASK_ADDR]) == '0 |=> !s.int_oe)
		else $error("masked condition drove interrupt");

	int_raise_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s.regs[`COND_ADDR] & s.regs[`MASK_ADDR]) != '0 |=> s.int_oe)
		else $error("unmasked condition missed interrupt");

endmodule // async_control_bus_port
`default_nettype wire

// File: src/cbus_port_pkg.sv
// types for the asynchronous register access port
// assumes the constants header is on the include path
`include "cbus_port_regs.svh"
package cbus_port_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SETTLE,
		ST_ACCESS,
		ST_HOLD
	} port_state_t;

	typedef logic [`REG_COUNT-1:0][`DATA_W-1:0] reg_file_t;

	typedef struct packed {
		port_state_t          st;
		logic                 ce_s1;
		logic                 ce_s2;
		logic                 rw_s1;
		logic                 rw_s2;
		logic [`ADDR_W-1:0]   addr_s1;
		logic [`ADDR_W-1:0]   addr_s2;
		logic [`DATA_W-1:0]   data_s1;
		logic [`DATA_W-1:0]   data_s2;
		logic                 par_s1;
		logic                 par_s2;
		logic                 rd;
		logic [`ADDR_W-1:0]   addr;
		logic [`DATA_W-1:0]   wdata;
		logic                 wpar;
		reg_file_t            regs;
		logic                 ack_oe;
		logic [`DATA_W-1:0]   dout;
		logic                 data_oe;
		logic                 pout;
		logic                 par_oe;
		logic                 int_oe;
		logic                 od_low;
	} port_state_vec_t;

endpackage

// File: src/cbus_port_regs.svh
// constants for the asynchronous register access port
// assumes one 100 MHz clock; the host side is fully asynchronous to it
// How it works
// - a cycle starts only when the host pulls the enable low, inputs already valid
// - read/write select high means read, low means write
// - completion is shown by pulling the open-drain acknowledge low
// - read data and parity are driven while acknowledge stays low
// - acknowledge stays low as long as the enable stays low
// - interrupt pin is pulled low while any unmasked condition is pending
// - each condition bit is gated by its own mask bit
// - sixty-four registers of eight bits behind a six-bit address
// - address bit five is the most significant, bit zero the least
// - parity is odd over eight data bits in both directions
// - bad write parity blocks the write and sets the parity error flag
`ifndef CBUS_PORT_REGS_SVH
`define CBUS_PORT_REGS_SVH

`define ADDR_W          6
`define DATA_W          8
`define REG_COUNT       64
`define COND_ADDR       6'h00
`define MASK_ADDR       6'h01
`define COND_RESET      8'h00
`define MASK_RESET      8'h00
`define REG_RESET       8'h00
`define PERR_BIT        0

`endif
